// ===== shared/fpshp_cfg.svh
`ifndef FPSHP_CFG_SVH
`define FPSHP_CFG_SVH

// array geometry
`define FPSHP_COLS 8'hDA
`define FPSHP_LAST_COL 8'hD9
`define FPSHP_ROWS 4'h8

// timing: figures in their own unit, cycle counts derived from the 20 MHz clock
`define FPSHP_CLK_MHZ 20
`define FPSHP_PRECHG_NS 200
`define FPSHP_PRECHG_CYC ((`FPSHP_PRECHG_NS * `FPSHP_CLK_MHZ + 999) / 1000)
`define FPSHP_DIS_STEP_NS 100
`define FPSHP_DIS_STEP_CYC ((`FPSHP_DIS_STEP_NS * `FPSHP_CLK_MHZ + 999) / 1000)
`define FPSHP_CONV_CYC 4

// register indices
`define FPSHP_IDX_ROW 8'h01
`define FPSHP_IDX_ADC 8'h03
`define FPSHP_IDX_DTIME 8'h06
`define FPSHP_IDX_DCUR 8'h07
`define FPSHP_IDX_CTL_A 8'h08
`define FPSHP_IDX_CTL_C 8'h0A
`define FPSHP_IDX_STAT 8'h0B
`define FPSHP_RST_REG 8'h00

// serial commands
`define FPSHP_CMD_RD 8'h03
`define FPSHP_CMD_WR 8'h02

// field positions
`define FPSHP_A_START 0
`define FPSHP_A_ALT 1
`define FPSHP_A_FIFO 2
`define FPSHP_A_IRQEN 3
`define FPSHP_C_GP0 0
`define FPSHP_C_GP1 1

`endif

// ===== shared/fpshp_pkg.sv
package fpshp_pkg;
	typedef logic [7:0] fpshp_byte_t;
	typedef enum logic [2:0] {ROW_IDLE, ROW_PRE, ROW_DIS, ROW_SH2, ROW_CONV} fpshp_row_t;
endpackage

// ===== src/fpshp_row.sv
`timescale 1ns/1ps
`include "fpshp_cfg.svh"
module fpshp_row (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       start,
	input  wire logic [2:0] row,
	input  wire logic [7:0] dtime,
	output logic      [2:0] row_sel,
	output logic            precharge,
	output logic            sh1,
	output logic            discharge,
	output logic            sh2,
	output logic      [7:0] col,
	output logic            adc_start,
	output logic            conv_done,
	output logic            busy
);
	fpshp_pkg::fpshp_row_t st_q;
	fpshp_pkg::fpshp_row_t st_d;
	logic [11:0] cnt_q;
	logic [7:0]  col_q;
	logic [2:0]  row_q;

	// longest discharge is 256 steps, well inside the counter
	wire [11:0] dis_len = 12'(({4'h0, dtime} + 12'h001) * 12'(`FPSHP_DIS_STEP_CYC));
	wire is_pre  = st_q == fpshp_pkg::ROW_PRE;
	wire is_dis  = st_q == fpshp_pkg::ROW_DIS;
	wire is_conv = st_q == fpshp_pkg::ROW_CONV;
	wire last_cnt = is_pre ? cnt_q == 12'(`FPSHP_PRECHG_CYC - 1) :
		is_dis ? cnt_q == dis_len - 12'h001 :
		is_conv ? cnt_q == 12'(`FPSHP_CONV_CYC - 1) : 1'b1;
	wire last_col = col_q == `FPSHP_LAST_COL;

	always_comb begin
		st_d = st_q;
		unique case (st_q)
			fpshp_pkg::ROW_IDLE: if (start) st_d = fpshp_pkg::ROW_PRE;
			fpshp_pkg::ROW_PRE:  if (last_cnt) st_d = fpshp_pkg::ROW_DIS;
			fpshp_pkg::ROW_DIS:  if (last_cnt) st_d = fpshp_pkg::ROW_SH2;
			fpshp_pkg::ROW_SH2:  st_d = fpshp_pkg::ROW_CONV;
			fpshp_pkg::ROW_CONV: if (last_cnt && last_col) st_d = fpshp_pkg::ROW_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q  <= fpshp_pkg::ROW_IDLE;
			cnt_q <= 12'h000;
			col_q <= 8'h00;
			row_q <= 3'h0;
		end else begin
			st_q  <= st_d;
			cnt_q <= (st_d != st_q || last_cnt) ? 12'h000 : cnt_q + 12'h001;
			if (st_q == fpshp_pkg::ROW_IDLE && start)
				row_q <= row;
			if (st_q == fpshp_pkg::ROW_SH2)
				col_q <= 8'h00;
			else if (is_conv && last_cnt)
				col_q <= col_q + 8'h01;
		end
	end

	assign row_sel   = row_q;
	assign precharge = is_pre;
	assign sh1       = is_pre;
	assign discharge = is_dis;
	assign sh2       = st_q == fpshp_pkg::ROW_SH2;
	assign col       = col_q;
	assign adc_start = is_conv && cnt_q == 12'h000;
	assign conv_done = is_conv && last_cnt;
	assign busy      = st_q != fpshp_pkg::ROW_IDLE;

	a_precharge_len: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(precharge) |-> precharge [*4] ##1 discharge)
		else $error("precharge phase length wrong");
	a_sh2_after_dis: assert property (@(posedge clk) disable iff (!rst_n)
		sh2 |-> $past(discharge) ##1 (adc_start && col == 8'h00))
		else $error("second hold strobe out of sequence");
	a_row_col_end: assert property (@(posedge clk) disable iff (!rst_n)
		conv_done && col == `FPSHP_LAST_COL |=> !busy)
		else $error("row did not end after last column");
endmodule

// ===== src/fpshp_spi.sv
`timescale 1ns/1ps
`include "fpshp_cfg.svh"
module fpshp_spi (
	input  wire logic        sclk,
	input  wire logic        scs_n,
	input  wire logic        rst_n,
	input  wire logic        mosi,
	input  wire logic [55:0] mir,
	input  wire logic        mir_req,
	output logic             mir_ack,
	output logic             miso,
	output logic             miso_oe,
	output logic             wr_tgl,
	output logic       [7:0] wr_idx,
	output logic       [7:0] wr_dat
);
	logic [4:0]  cnt_q;
	logic [7:0]  sh_q;
	logic [7:0]  cmd_q;
	logic [7:0]  idx_q;
	logic [2:0]  rq_q;
	logic [55:0] loc_q;

	// the frame's own select ends every frame, so no edge after it is needed
	wire frame_rst = scs_n | ~rst_n;
	wire [7:0] rx = {sh_q[6:0], mosi};
	wire is_rd = cmd_q == `FPSHP_CMD_RD;
	wire [7:0] rd_byte = idx_q == `FPSHP_IDX_ROW   ? loc_q[55:48] :
		idx_q == `FPSHP_IDX_ADC   ? loc_q[47:40] :
		idx_q == `FPSHP_IDX_STAT  ? loc_q[39:32] :
		idx_q == `FPSHP_IDX_CTL_C ? loc_q[31:24] :
		idx_q == `FPSHP_IDX_CTL_A ? loc_q[23:16] :
		idx_q == `FPSHP_IDX_DCUR  ? loc_q[15:8] :
		idx_q == `FPSHP_IDX_DTIME ? loc_q[7:0] : 8'h00;

	always_ff @(posedge sclk or posedge frame_rst) begin
		if (frame_rst) begin
			cnt_q <= 5'h00;
			sh_q  <= 8'h00;
			cmd_q <= 8'h00;
			idx_q <= 8'h00;
		end else begin
			// reads repeat the byte while select stays low
			cnt_q <= (cnt_q == 5'h17) ? 5'h10 : cnt_q + 5'h01;
			sh_q  <= rx;
			if (cnt_q == 5'h07)
				cmd_q <= rx;
			if (cnt_q == 5'h0F)
				idx_q <= rx;
		end
	end

	// the write word stays put until the next write, so the toggle alone crosses
	always_ff @(posedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			wr_tgl  <= 1'b0;
			wr_idx  <= 8'h00;
			wr_dat  <= 8'h00;
			rq_q    <= 3'h0;
			loc_q   <= 56'h0;
			mir_ack <= 1'b0;
		end else begin
			if (!scs_n && cnt_q == 5'h17 && cmd_q == `FPSHP_CMD_WR) begin
				wr_tgl <= ~wr_tgl;
				wr_idx <= idx_q;
				wr_dat <= rx;
			end
			rq_q <= {rq_q[1:0], mir_req};
			if (rq_q[2] != rq_q[1]) begin
				loc_q   <= mir;
				mir_ack <= rq_q[1];
			end
		end
	end

	always_ff @(negedge sclk or posedge frame_rst) begin
		if (frame_rst) begin
			miso    <= 1'b0;
			miso_oe <= 1'b0;
		end else if (cnt_q[4] && is_rd) begin
			miso    <= rd_byte[3'h7 - cnt_q[2:0]];
			miso_oe <= 1'b1;
		end
	end
endmodule

// ===== src/fpshp_host_port.sv
`timescale 1ns/1ps
`include "fpshp_cfg.svh"
// Summary of operation
// - array is 218 columns by 8 rows, two hold banks per column.
// - image captured one row at a time: pre-charge then discharge.
// - pre-charge charges row plates and strobes the first hold bank.
// - discharge through current source, then strobe second hold bank after discharge time.
// - discharge time and current come from their registers.
// - alternate input select bit routes the converter to the alternate analog pin.
// - parallel address line low reaches index, high reaches data register.
// - in mode 0, selected only with low select low and high select high.
// - in mode 1, shared pins become serial clock and serial select.
// - interrupt pin floats when idle, pulled low on an enabled event.
// - interrupt works in both bus modes.
// - wait low on converter read while busy or buffer empty, until done; buffer empty counts only with the FIFO bit set.
// - serial output driven only while transmitting, floating otherwise.
// - general outputs follow bits 0 and 1 of control register C.
// - serial read is command 0x03, index byte, then register data out.
// - serial write is command 0x02, index byte, one data byte.
// - serial input sampled on rising edge, output on falling, MSB first.
// - index register holds until rewritten or reset.
module fpshp_host_port (
	input  wire logic       CLK_SYS,
	input  wire logic       RST_N,
	input  wire logic       MODE_SEL,
	input  wire logic       SELECT_N_OR_SPI_SELECT,
	input  wire logic       SELECT_HI_OR_SERIAL_CLOCK,
	input  wire logic       REGISTER_SELECT_LINE,
	input  wire logic       RD_N,
	input  wire logic       WR_N,
	input  wire logic [7:0] DATA_I,
	output logic      [7:0] DATA_O,
	output logic            DATA_OE,
	output logic            WAIT_N,
	output logic            IRQ_OUT_N_O,
	output logic            IRQ_OUT_N_OE,
	input  wire logic       MOSI,
	output logic            MISO_O,
	output logic            MISO_OE,
	output logic            GP_OUTPUT_ZERO,
	output logic            GP_OUTPUT_ONE,
	output logic      [2:0] ROW_SEL,
	output logic            PRECHARGE,
	output logic            SH1_STROBE,
	output logic            DISCHARGE_ON,
	output logic      [7:0] DISCHARGE_CURRENT,
	output logic            SH2_STROBE,
	output logic      [7:0] COL_SEL,
	output logic            ADC_START,
	output logic            ALT_INPUT_SELECT,
	input  wire logic [7:0] ADC_DATA
);
	fpshp_pkg::fpshp_byte_t index_q;
	fpshp_pkg::fpshp_byte_t dtime_q;
	fpshp_pkg::fpshp_byte_t dcur_q;
	fpshp_pkg::fpshp_byte_t ctlc_q;
	fpshp_pkg::fpshp_byte_t pix_q;
	fpshp_pkg::fpshp_byte_t data_o_q;
	logic [2:0]  row_q;
	logic [3:1]  ctla_q;
	logic [13:0] s1_q;
	logic [13:0] s2_q;
	logic [13:0] s3_q;
	logic        rd_prev_q;
	logic        oe_q;
	logic        valid_q;
	logic        valid_d;
	logic        wait_q;
	logic        wait_d;
	logic        irq_q;
	logic [2:0]  sw_q;
	logic [1:0]  ak_q;
	logic [55:0] mir_q;
	logic        mreq_q;
	logic        busy;
	logic        conv_done;
	logic        spi_tgl;
	logic [7:0]  spi_idx;
	logic [7:0]  spi_dat;
	logic        spi_ack;

	// the mode and parallel-bus pins are brought in through two flops; the third stage finds edges
	wire [13:0] pin_raw = {MODE_SEL, SELECT_N_OR_SPI_SELECT, SELECT_HI_OR_SERIAL_CLOCK,
		REGISTER_SELECT_LINE, RD_N, WR_N, DATA_I};
	wire       mode_s  = s2_q[13];
	wire       cs_n_s  = s2_q[12];
	wire       cs_hi_s = s2_q[11];
	wire       a0_s    = s3_q[10];
	// reads take the address with the strobe, writes the one held before the rise
	wire       a0_r    = s2_q[10];
	wire       rd_n_s  = s2_q[9];
	wire       wr_n_s  = s2_q[8];
	wire       wr_n_d  = s3_q[8];
	wire [7:0] din     = s3_q[7:0];

	// parallel decode
	wire bus_sel  = !mode_s && !cs_n_s && cs_hi_s;
	wire par_wr   = bus_sel && rd_n_s && wr_n_s && !wr_n_d;
	wire rd_act   = bus_sel && !rd_n_s && wr_n_s;
	wire rd_begin = rd_act && !rd_prev_q;
	wire idx_wr   = par_wr && !a0_s;
	wire spi_ev   = mode_s && (sw_q[2] ^ sw_q[1]);
	wire reg_wr   = (par_wr && a0_s) || spi_ev;
	wire [7:0] reg_idx = spi_ev ? spi_idx : index_q;
	wire [7:0] reg_dat = spi_ev ? spi_dat : din;
	wire wr_ctla  = reg_wr && reg_idx == `FPSHP_IDX_CTL_A;
	wire start    = wr_ctla && reg_dat[`FPSHP_A_START];
	wire fifo_en  = ctla_q[`FPSHP_A_FIFO];
	wire rd_adc   = rd_begin && a0_r && index_q == `FPSHP_IDX_ADC;
	wire [7:0] stat = {6'h00, valid_q, busy};

	// register read selection, unmapped indices read zero
	wire [7:0] rd_val = index_q == `FPSHP_IDX_ROW   ? {5'h00, row_q} :
		index_q == `FPSHP_IDX_ADC   ? pix_q :
		index_q == `FPSHP_IDX_DTIME ? dtime_q :
		index_q == `FPSHP_IDX_DCUR  ? dcur_q :
		index_q == `FPSHP_IDX_CTL_A ? {4'h0, ctla_q, 1'b0} :
		index_q == `FPSHP_IDX_CTL_C ? ctlc_q :
		index_q == `FPSHP_IDX_STAT  ? stat : 8'h00;
	wire [55:0] mir_live = {5'h00, row_q, pix_q, stat, ctlc_q,
		{4'h0, ctla_q, 1'b0}, dcur_q, dtime_q};

	// a fresh pixel beats the read that would clear the old one
	assign valid_d = conv_done || (valid_q && !rd_adc);
	// wait stays low until a conversion finishes, even when none is running
	assign wait_d = (rd_adc && (busy || (fifo_en && !valid_q))) || (wait_q && !conv_done);

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			s1_q <= 14'h0000;
			s2_q <= 14'h0000;
			s3_q <= 14'h0000;
			sw_q <= 3'h0;
			ak_q <= 2'h0;
		end else begin
			s1_q <= pin_raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
			sw_q <= {sw_q[1:0], spi_tgl};
			ak_q <= {ak_q[0], spi_ack};
		end
	end

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			index_q <= `FPSHP_RST_REG;
		end else if (idx_wr) begin
			index_q <= din;
		end
	end

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			row_q   <= 3'h0;
			dtime_q <= `FPSHP_RST_REG;
			dcur_q  <= `FPSHP_RST_REG;
			ctla_q  <= 3'h0;
			ctlc_q  <= `FPSHP_RST_REG;
		end else if (reg_wr) begin
			if (reg_idx == `FPSHP_IDX_ROW)
				row_q <= reg_dat[2:0];
			if (reg_idx == `FPSHP_IDX_DTIME)
				dtime_q <= reg_dat;
			if (reg_idx == `FPSHP_IDX_DCUR)
				dcur_q <= reg_dat;
			if (wr_ctla)
				ctla_q <= reg_dat[3:1];
			if (reg_idx == `FPSHP_IDX_CTL_C)
				ctlc_q <= reg_dat;
		end
	end

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			pix_q    <= 8'h00;
			valid_q  <= 1'b0;
			wait_q   <= 1'b0;
			irq_q    <= 1'b0;
			rd_prev_q <= 1'b0;
			oe_q     <= 1'b0;
			data_o_q <= 8'h00;
		end else begin
			if (conv_done)
				pix_q <= ADC_DATA;
			valid_q   <= valid_d;
			wait_q    <= wait_d;
			irq_q     <= ctla_q[`FPSHP_A_IRQEN] && valid_d;
			rd_prev_q <= rd_act;
			oe_q      <= rd_act;
			if (rd_act)
				data_o_q <= a0_r ? rd_val : index_q;
		end
	end

	// register snapshot for the serial side, handed over by req/ack
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			mir_q  <= 56'h0;
			mreq_q <= 1'b0;
		end else if (ak_q[1] == mreq_q) begin
			mir_q  <= mir_live;
			mreq_q <= ~mreq_q;
		end
	end

	fpshp_row u_row (
		.clk       (CLK_SYS),
		.rst_n     (RST_N),
		.start     (start),
		.row       (row_q),
		.dtime     (dtime_q),
		.row_sel   (ROW_SEL),
		.precharge (PRECHARGE),
		.sh1       (SH1_STROBE),
		.discharge (DISCHARGE_ON),
		.sh2       (SH2_STROBE),
		.col       (COL_SEL),
		.adc_start (ADC_START),
		.conv_done (conv_done),
		.busy      (busy)
	);

	// select is forced high outside serial mode, holding the serial side in reset
	fpshp_spi u_spi (
		.sclk    (SELECT_HI_OR_SERIAL_CLOCK),
		.scs_n   (SELECT_N_OR_SPI_SELECT || !mode_s),
		.rst_n   (RST_N),
		.mosi    (MOSI),
		.mir     (mir_q),
		.mir_req (mreq_q),
		.mir_ack (spi_ack),
		.miso    (MISO_O),
		.miso_oe (MISO_OE),
		.wr_tgl  (spi_tgl),
		.wr_idx  (spi_idx),
		.wr_dat  (spi_dat)
	);

	assign DATA_O            = data_o_q;
	assign DATA_OE           = oe_q;
	assign WAIT_N            = !wait_q;
	assign IRQ_OUT_N_O       = 1'b0;
	assign IRQ_OUT_N_OE      = irq_q;
	assign GP_OUTPUT_ZERO    = ctlc_q[`FPSHP_C_GP0];
	assign GP_OUTPUT_ONE     = ctlc_q[`FPSHP_C_GP1];
	assign DISCHARGE_CURRENT = dcur_q;
	assign ALT_INPUT_SELECT  = ctla_q[`FPSHP_A_ALT];

	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);

	a_index_hold: assert property (!idx_wr |=> $stable(index_q))
		else $error("index register changed without a write");
	a_index_serial: assert property (mode_s && $past(mode_s) |=> $stable(index_q))
		else $error("index register moved in serial mode");
	a_gp_follow: assert property (reg_wr && reg_idx == `FPSHP_IDX_CTL_C
		|=> GP_OUTPUT_ONE == $past(reg_dat[1]) && GP_OUTPUT_ZERO == $past(reg_dat[0]))
		else $error("general outputs do not follow control C");
	a_alt_select: assert property (wr_ctla |=> ALT_INPUT_SELECT == $past(reg_dat[1]))
		else $error("alternate input select not taken");
	a_wait_cause: assert property ($fell(WAIT_N) |-> $past(rd_adc))
		else $error("wait asserted without a converter read");
	a_wait_hold: assert property (!WAIT_N && !conv_done |=> !WAIT_N)
		else $error("wait released before conversion done");
	a_wait_busy: assert property (rd_adc && busy |=> !WAIT_N)
		else $error("busy converter read did not assert wait");
	a_irq_drive: assert property (IRQ_OUT_N_OE |-> $past(ctla_q[3] && valid_d) && !IRQ_OUT_N_O)
		else $error("interrupt driven without an enabled event");
	a_deselect_quiet: assert property (!bus_sel |=> !DATA_OE)
		else $error("data bus driven while deselected");
	a_start_capture: assert property (start && !busy |=> PRECHARGE && SH1_STROBE)
		else $error("row capture did not start with precharge");
endmodule

// ===== bench/fpshp_host_model.sv
`timescale 1ns/1ps
// host seen from the device pins: parallel master and serial master in one
module fpshp_host_model (
	input  wire logic       clk,
	output logic            sel_n,
	output logic            sel_hi_sclk,
	output logic            rs,
	output logic            rd_n,
	output logic            wr_n,
	output logic      [7:0] dout,
	output logic            mosi,
	input  wire logic [7:0] din,
	input  wire logic       wait_n,
	input  wire logic       miso,
	input  wire logic       miso_oe
);
	initial begin
		sel_n = 1'b1;
		sel_hi_sclk = 1'b0;
		rs = 1'b0;
		rd_n = 1'b1;
		wr_n = 1'b1;
		dout = 8'h00;
		mosi = 1'b0;
	end

	// cs1 low gives a deselected attempt; strobes held well past the 3-stage sync
	task automatic par_acc(input logic a, input logic wr, input logic [7:0] d,
			input logic cs1, output logic [7:0] q, output logic waited);
		int n;
		@(posedge clk);
		sel_n <= 1'b0;
		sel_hi_sclk <= cs1;
		rs <= a;
		dout <= d;
		rd_n <= wr;
		wr_n <= ~wr;
		waited = 1'b0;
		n = 0;
		repeat (5) @(posedge clk);
		#1;
		while (wait_n !== 1'b1 && n < 3000) begin
			waited = 1'b1;
			n++;
			@(posedge clk);
			#1;
		end
		repeat (2) @(posedge clk);
		q = din;
		rd_n <= 1'b1;
		wr_n <= 1'b1;
		repeat (2) @(posedge clk);
		dout <= ~d; // released bus must not keep showing the old byte
		sel_n <= 1'b1;
		sel_hi_sclk <= 1'b0;
		repeat (4) @(posedge clk);
	endtask

	// mode 0,0 frame: mosi set while sclk low, miso taken at each rising edge of the last byte
	task automatic spi_frame(input logic [23:0] tx, output logic [7:0] q,
			output logic oe_seen);
		oe_seen = 1'b0;
		q = 8'h00;
		sel_n = 1'b0;
		#20;
		for (int i = 23; i >= 0; i--) begin
			mosi = tx[i];
			#16 sel_hi_sclk = 1'b1;
			if (i < 8) begin
				q[i] = miso;
				oe_seen = oe_seen | (miso_oe === 1'b1);
			end
			#16 sel_hi_sclk = 1'b0;
		end
		#20 sel_n = 1'b1;
		mosi = ~mosi;
		#200;
	endtask
endmodule

// ===== bench/fpshp_host_port_tb.sv
`timescale 1ns/1ps
`include "fpshp_cfg.svh"
module fpshp_host_port_tb;
	logic       clk_sys;
	logic       rst_n;
	logic       mode_sel;
	logic [7:0] adc_data;
	logic       sel_n, sel_hi, rs, rd_n, wr_n, mosi;
	logic [7:0] data_i, data_o, dis_cur, col_sel;
	logic       data_oe, wait_n, irq_o, irq_oe, miso_o, miso_oe, gp0, gp1;
	logic [2:0] row_sel;
	logic       pre, sh1, dis_on, sh2, adc_st, alt_sel;
	int         num_errors = 0;
	int         num_checks = 0;
	int         pre_n = 0, dis_n = 0, sh2_n = 0, adc_n = 0;
	logic [7:0] last_col = 8'h00;
	logic [7:0] q;
	logic       w;
	// idx, write data, read-back expectation
	logic [23:0] rows [5] = '{24'h06_5A_5A, 24'h07_C3_C3, 24'h0A_03_03, 24'h01_FF_07,
		24'h20_77_00};

	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	fpshp_host_model host (.clk(clk_sys), .sel_n(sel_n), .sel_hi_sclk(sel_hi), .rs(rs),
		.rd_n(rd_n), .wr_n(wr_n), .dout(data_i), .mosi(mosi), .din(data_o),
		.wait_n(wait_n), .miso(miso_o), .miso_oe(miso_oe));

	fpshp_host_port dut (.CLK_SYS(clk_sys), .RST_N(rst_n), .MODE_SEL(mode_sel),
		.SELECT_N_OR_SPI_SELECT(sel_n), .SELECT_HI_OR_SERIAL_CLOCK(sel_hi),
		.REGISTER_SELECT_LINE(rs), .RD_N(rd_n), .WR_N(wr_n), .DATA_I(data_i),
		.DATA_O(data_o), .DATA_OE(data_oe), .WAIT_N(wait_n), .IRQ_OUT_N_O(irq_o),
		.IRQ_OUT_N_OE(irq_oe), .MOSI(mosi), .MISO_O(miso_o), .MISO_OE(miso_oe),
		.GP_OUTPUT_ZERO(gp0), .GP_OUTPUT_ONE(gp1), .ROW_SEL(row_sel), .PRECHARGE(pre),
		.SH1_STROBE(sh1), .DISCHARGE_ON(dis_on), .DISCHARGE_CURRENT(dis_cur),
		.SH2_STROBE(sh2), .COL_SEL(col_sel), .ADC_START(adc_st),
		.ALT_INPUT_SELECT(alt_sel), .ADC_DATA(adc_data));

	// converter stand-in: result follows the column so each pixel is known
	always_ff @(posedge clk_sys) begin
		adc_data <= col_sel ^ 8'hA5;
	end

	always @(posedge clk_sys) begin
		pre_n += (pre === 1'b1 && sh1 === 1'b1);
		dis_n += (dis_on === 1'b1);
		sh2_n += (sh2 === 1'b1);
		adc_n += (adc_st === 1'b1);
		if (adc_st === 1'b1) last_col = col_sel;
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d);
		host.par_acc(1'b0, 1'b1, idx, 1'b1, q, w);
		host.par_acc(1'b1, 1'b1, d, 1'b1, q, w);
	endtask

	task automatic reg_rd(input logic [7:0] idx, output logic [7:0] d);
		host.par_acc(1'b0, 1'b1, idx, 1'b1, q, w);
		host.par_acc(1'b1, 1'b0, 8'h00, 1'b1, d, w);
	endtask

	task automatic give_verdict();
		if (num_errors == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	initial begin
		#(400_000);
		num_errors++;
		give_verdict();
	end

	initial begin
		logic [7:0] d;
		logic       oe;
		int         n;
		rst_n = 1'b0;
		mode_sel = 1'b0;
		adc_data = 8'h00;
		repeat (16) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		check(8'(wait_n), 8'h01);
		check({irq_oe, miso_oe, data_oe, gp1, gp0}, 8'h00);
		foreach (rows[i]) begin
			reg_wr(rows[i][23:16], rows[i][15:8]);
			host.par_acc(1'b1, 1'b0, 8'h00, 1'b1, d, w);
			check(d, rows[i][7:0]);
			host.par_acc(1'b1, 1'b0, 8'h00, 1'b1, d, w);
			check(d, rows[i][7:0]);
		end
		check(dis_cur, 8'hC3);
		check({gp1, gp0}, 8'h03);
		host.par_acc(1'b1, 1'b1, 8'h00, 1'b0, q, w); // cs1 low: must be ignored
		check({gp1, gp0}, 8'h03);
		// capture with alternate input and interrupt enabled, converter read while busy
		host.par_acc(1'b0, 1'b1, `FPSHP_IDX_CTL_A, 1'b1, q, w);
		host.par_acc(1'b1, 1'b1, 8'h0B, 1'b1, q, w);
		check(8'(alt_sel), 8'h01);
		reg_rd(`FPSHP_IDX_ADC, d);
		check(8'(w), 8'h01);
		check(d, 8'hA5);
		n = 0;
		while (adc_n < `FPSHP_COLS && n < 3000) begin
			n++;
			@(posedge clk_sys);
		end
		repeat (8) @(posedge clk_sys);
		check(8'(pre_n), 8'(`FPSHP_PRECHG_CYC));
		check(8'(dis_n), 8'((8'h5A + 1) * `FPSHP_DIS_STEP_CYC));
		check(8'(sh2_n), 8'h01);
		check(8'(adc_n), `FPSHP_COLS);
		check(last_col, `FPSHP_LAST_COL);
		check({5'h00, row_sel}, 8'h07);
		check({irq_oe, irq_o}, 8'h02);
		// serial mode
		mode_sel <= 1'b1;
		repeat (6) @(posedge clk_sys);
		host.spi_frame({`FPSHP_CMD_WR, `FPSHP_IDX_CTL_C, 8'h02}, d, oe);
		repeat (6) @(posedge clk_sys);
		check({gp1, gp0}, 8'h02);
		host.spi_frame({8'h05, `FPSHP_IDX_CTL_C, 8'h01}, d, oe);
		repeat (6) @(posedge clk_sys);
		check({gp1, gp0}, 8'h02);
		host.par_acc(1'b1, 1'b1, 8'h00, 1'b1, q, w); // parallel strobes in serial mode
		check({gp1, gp0}, 8'h02);
		host.spi_frame({`FPSHP_CMD_RD, `FPSHP_IDX_DCUR, 8'h00}, d, oe);
		check(d, 8'hC3);
		check({oe, miso_oe}, 8'h02);
		check(8'(irq_oe), 8'h01);
		give_verdict();
	end
endmodule
